// ### inc/erc_pkg.sv
// Package for the auxiliary regulator configuration controller.
// Assumes one core clock; mode codes come from the chip's mode state machine.
package erc_pkg;

  typedef enum logic [2:0] {
    ERC_MODE_INIT,
    ERC_MODE_NORMAL,
    ERC_MODE_STOP,
    ERC_MODE_SLEEP,
    ERC_MODE_RESTART,
    ERC_MODE_FAILSAFE
  } erc_mode_t;

  typedef enum logic [1:0] {
    ERC_CFG_NONE,
    ERC_CFG_INDEP,
    ERC_CFG_SHARE
  } erc_cfg_t;

  localparam logic       ERC_RST_ENABLE  = 1'b0;
  localparam logic       ERC_RST_FLAG    = 1'b0;
  localparam logic       ERC_VSEL_5V0    = 1'b0;
  localparam logic       ERC_VSEL_3V3    = 1'b1;
  localparam erc_cfg_t   ERC_RST_CFG     = ERC_CFG_NONE;

endpackage

// ### hdl/erc_ctrl.sv
// Auxiliary regulator configuration, lock, mode gating and flag logic.
// Assumes SPI writes arrive as one-cycle strobes with the written bits; nrst is power-on reset only.
`timescale 1ns/10ps
`default_nettype none
module erc_ctrl
  import erc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic      core_clk,
  input  wire logic      nrst,
  // Soft reset and mode
  input  wire logic      soft_rst,
  input  wire erc_mode_t sbc_mode,
  // SPI control write strobe and bits
  input  wire logic      ctrl_wr,
  input  wire logic      wr_aux_out_enable,
  input  wire logic      wr_load_share_select,
  input  wire logic      wr_aux_voltage_select,
  input  wire logic      wr_load_share_stop_keep_on,
  input  wire logic      wr_aux_keep_on_supply_low,
  // SPI flag clear strobes
  input  wire logic      clr_overcurrent,
  input  wire logic      clr_undervoltage,
  // Analog status
  input  wire logic      shunt_at_threshold,
  input  wire logic      aux_out_low,
  input  wire logic      supply_low,
  // Control outputs
  output logic           aux_regulator_on,
  output logic           aux_current_limit,
  output logic           aux_voltage_3v3,
  output logic           spi_fail_set,
  // Readback
  output logic           aux_out_enable,
  output logic           load_share_select,
  output logic           load_share_stop_keep_on,
  output logic           aux_voltage_select,
  output logic           aux_keep_on_supply_low,
  output logic           aux_overcurrent_flag,
  output logic           aux_undervoltage_flag,
  output erc_cfg_t       cfg_locked
);

  //////////////////////////////////////////////////////////////////////////////
  // Block state
  typedef struct packed {
    erc_cfg_t cfg;
    logic     out_en;
    logic     ls_sel;
    logic     stp_on;
    logic     vsel;
    logic     vs_keep;
    logic     oc;
    logic     uv;
    logic     fail;
    logic     reg_on;
    logic     ilim;
  } erc_state_t;

  erc_state_t st;
  erc_state_t next_st;

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode
  function automatic logic mode_is_normal(input erc_mode_t m);
    return (m == ERC_MODE_NORMAL);
  endfunction

  // Independent regulator off only in init and fail-safe
  function automatic logic indep_mode_ok(input erc_mode_t m);
    logic ok;
    case (m)
      ERC_MODE_INIT: begin
        ok = 1'b0;
      end
      ERC_MODE_NORMAL: begin
        ok = 1'b1;
      end
      ERC_MODE_STOP: begin
        ok = 1'b1;
      end
      ERC_MODE_SLEEP: begin
        ok = 1'b1;
      end
      ERC_MODE_RESTART: begin
        ok = 1'b1;
      end
      ERC_MODE_FAILSAFE: begin
        ok = 1'b0;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // Sharing runs in normal, and in stop only when kept on
  function automatic logic share_mode_ok(input erc_mode_t m, input logic keep);
    logic ok;
    case (m)
      ERC_MODE_INIT: begin
        ok = 1'b0;
      end
      ERC_MODE_NORMAL: begin
        ok = 1'b1;
      end
      ERC_MODE_STOP: begin
        ok = keep;
      end
      ERC_MODE_SLEEP: begin
        ok = 1'b0;
      end
      ERC_MODE_RESTART: begin
        ok = 1'b0;
      end
      ERC_MODE_FAILSAFE: begin
        ok = 1'b0;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  function automatic logic cfg_is_indep(input erc_cfg_t c);
    return (c == ERC_CFG_INDEP);
  endfunction

  function automatic logic cfg_is_share(input erc_cfg_t c);
    return (c == ERC_CFG_SHARE);
  endfunction

  // First select decides the lock; share select wins a tie
  function automatic erc_cfg_t first_select(
    input logic ls_bit,
    input logic en_bit
  );
    erc_cfg_t c;
    if (ls_bit) begin
      c = ERC_CFG_SHARE;
    end else if (en_bit) begin
      c = ERC_CFG_INDEP;
    end else begin
      c = ERC_CFG_NONE;
    end
    return c;
  endfunction

  // Locked sharing refuses a cleared select or a set enable
  function automatic logic share_write_refused(
    input logic ls_bit,
    input logic en_bit
  );
    return !ls_bit || en_bit;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flag, set wins over clear
  function automatic logic sticky_next(
    input logic cur,
    input logic set_ev,
    input logic clr_ev
  );
    logic res;
    res = cur;
    if (set_ev) begin
      res = 1'b1;
    end else if (clr_ev) begin
      res = 1'b0;
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Decoded conditions
  logic normal;
  logic wr_take;
  logic indep_run;
  logic share_run;
  logic run_any;
  logic supply_ok;
  logic oc_set;
  logic uv_set;

  assign normal    = mode_is_normal(sbc_mode);
  // Writes only land in normal mode
  assign wr_take   = ctrl_wr && normal && !soft_rst;
  assign indep_run = cfg_is_indep(st.cfg)
                   && st.out_en
                   && indep_mode_ok(sbc_mode);
  assign share_run = cfg_is_share(st.cfg)
                   && st.ls_sel
                   && share_mode_ok(sbc_mode, st.stp_on);
  assign run_any   = indep_run || share_run;
  // Supply dip turns regulator off unless kept on
  assign supply_ok = !supply_low || st.vs_keep;
  assign oc_set    = cfg_is_indep(st.cfg) && shunt_at_threshold;
  assign uv_set    = indep_run && aux_out_low;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st      = st;
    next_st.fail = 1'b0;
    if (soft_rst) begin
      // Control bits reset except share select, which is set when shared; lock held
      next_st.out_en  = ERC_RST_ENABLE;
      next_st.stp_on  = ERC_RST_ENABLE;
      next_st.vs_keep = ERC_RST_ENABLE;
      next_st.vsel    = ERC_VSEL_5V0;
      if (cfg_is_share(st.cfg)) begin
        next_st.ls_sel = 1'b1;
      end
    end else if (wr_take) begin
      next_st.stp_on  = wr_load_share_stop_keep_on;
      next_st.vs_keep = wr_aux_keep_on_supply_low;
      case (st.cfg)
        ERC_CFG_NONE: begin
          next_st.cfg = first_select(wr_load_share_select, wr_aux_out_enable);
          if (wr_load_share_select) begin
            next_st.ls_sel = 1'b1;
            next_st.out_en = 1'b0;
          end else if (wr_aux_out_enable) begin
            next_st.out_en = 1'b1;
            next_st.vsel   = wr_aux_voltage_select;
          end
        end
        ERC_CFG_INDEP: begin
          // Share select dropped, no failure
          next_st.out_en = wr_aux_out_enable;
          next_st.vsel   = wr_aux_voltage_select;
        end
        ERC_CFG_SHARE: begin
          // Voltage select has no effect here
          if (share_write_refused(wr_load_share_select, wr_aux_out_enable)) begin
            next_st.fail = 1'b1;
          end
        end
        default: begin
          next_st.cfg = ERC_CFG_NONE;
        end
      endcase
    end
    next_st.reg_on = run_any && supply_ok;
    next_st.ilim   = indep_run && shunt_at_threshold;
    next_st.oc     = sticky_next(st.oc, oc_set, clr_overcurrent);
    next_st.uv     = sticky_next(st.uv, uv_set, clr_undervoltage);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers; only power-on reset clears the lock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st     <= '0;
      st.cfg <= ERC_RST_CFG;
      st.oc  <= ERC_RST_FLAG;
      st.uv  <= ERC_RST_FLAG;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control outputs
  assign aux_regulator_on        = st.reg_on;
  assign aux_current_limit       = st.ilim;
  assign aux_voltage_3v3         = cfg_is_indep(st.cfg) && (st.vsel == ERC_VSEL_3V3);
  assign spi_fail_set            = st.fail;

  //////////////////////////////////////////////////////////////////////////////
  // Readback
  assign aux_out_enable          = st.out_en;
  assign load_share_select       = st.ls_sel;
  assign load_share_stop_keep_on = st.stp_on;
  assign aux_voltage_select      = st.vsel;
  assign aux_keep_on_supply_low  = st.vs_keep;
  assign aux_overcurrent_flag    = st.oc;
  assign aux_undervoltage_flag   = st.uv;
  assign cfg_locked              = st.cfg;

endmodule
`default_nettype wire

// ### bench/erc_ctrl_monitor.sv
// Port assertions; bound into erc_ctrl, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module erc_ctrl_monitor
  import erc_pkg::*;
(
  input wire logic      core_clk,
  input wire logic      nrst,
  input wire logic      soft_rst,
  input wire erc_mode_t sbc_mode,
  input wire logic      ctrl_wr,
  input wire logic      wr_load_share_select,
  input wire logic      shunt_at_threshold,
  input wire logic      aux_regulator_on,
  input wire logic      spi_fail_set,
  input wire logic      load_share_stop_keep_on,
  input wire logic      aux_overcurrent_flag,
  input wire erc_cfg_t  cfg_locked
);
  wire ind = cfg_locked == ERC_CFG_INDEP;
  wire shr = cfg_locked == ERC_CFG_SHARE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr; ctrl_wr && !soft_rst && sbc_mode == ERC_MODE_NORMAL; endsequence
  sequence s_stop; shr && sbc_mode == ERC_MODE_STOP; endsequence
  property p_fail; s_wr ##0 (shr && !wr_load_share_select) |=> spi_fail_set; endproperty
  a_fail: assert property (p_fail) else $error("no fail");
  property p_quiet; ind |=> !spi_fail_set; endproperty
  a_quiet: assert property (p_quiet) else $error("fail");
  property p_lock; cfg_locked != ERC_CFG_NONE |=> $stable(cfg_locked); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_oc; ind && shunt_at_threshold |=> aux_overcurrent_flag; endproperty
  a_oc: assert property (p_oc) else $error("oc");
  property p_och; aux_overcurrent_flag && shunt_at_threshold |=> aux_overcurrent_flag; endproperty
  a_och: assert property (p_och) else $error("oc hold");
  property p_nooc; shr && !aux_overcurrent_flag |=> !aux_overcurrent_flag; endproperty
  a_nooc: assert property (p_nooc) else $error("oc share");
  property p_stop; s_stop ##0 !load_share_stop_keep_on |=> !aux_regulator_on; endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_fs; sbc_mode == ERC_MODE_FAILSAFE |=> !aux_regulator_on; endproperty
  a_fs: assert property (p_fs) else $error("failsafe");
endmodule
bind erc_ctrl erc_ctrl_monitor u_erc_ctrl_monitor (.*);
`default_nettype wire

// ### bench/erc_host_model.sv
// Host model: one-cycle writes and clears on core_clk.
`timescale 1ns/10ps
`default_nettype none
module erc_host_model (
  input  wire logic core_clk,
  output logic      ctrl_wr = 1'b0,
  output logic      clr_overcurrent = 1'b0,
  output logic      wr_aux_out_enable,
  output logic      wr_load_share_select,
  output logic      wr_aux_voltage_select,
  output logic      wr_load_share_stop_keep_on,
  output logic      wr_aux_keep_on_supply_low
);
  logic [4:0] b = 5'h00;
  assign {wr_aux_out_enable, wr_load_share_select, wr_aux_voltage_select,
          wr_load_share_stop_keep_on, wr_aux_keep_on_supply_low} = b;
  // Write when w, else clear
  task automatic send(input logic w, input logic [4:0] v);
    @(posedge core_clk);
    ctrl_wr <= w;
    clr_overcurrent <= !w;
    b <= {v[4] & !v[3], v[3:0]};
    @(posedge core_clk);
    {ctrl_wr, clr_overcurrent} <= 2'h0;
  endtask
endmodule
`default_nettype wire

// ### bench/erc_ctrl_tb.sv
// Bench for erc_ctrl; host model writes, bench drives mode and analog.
`timescale 1ns/10ps
`default_nettype none
module erc_ctrl_tb;
  import erc_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, shunt_at_threshold = 1'b0, aux_out_low = 1'b0;
  logic ctrl_wr, clr_overcurrent, wr_aux_out_enable, wr_load_share_select, wr_aux_voltage_select;
  logic wr_load_share_stop_keep_on, wr_aux_keep_on_supply_low, aux_regulator_on, spi_fail_set;
  logic aux_current_limit, load_share_select, load_share_stop_keep_on, aux_overcurrent_flag;
  logic aux_undervoltage_flag, aux_voltage_3v3, aux_out_enable;
  logic soft_rst = 1'b0, clr_undervoltage = 1'b0, supply_low = 1'b0;
  erc_mode_t sbc_mode = ERC_MODE_INIT;
  erc_cfg_t cfg_locked;
  int err_total = 0, num_checks = 0;
  erc_ctrl u_erc_ctrl (.*, .aux_voltage_select(), .aux_keep_on_supply_low());
  erc_host_model u_erc_host_model (.*);
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %0h vs %0h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic mode(input erc_mode_t m);
    @(posedge core_clk) sbc_mode <= m;
    tick(2);
  endtask
  task automatic t_indep;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    sbc_mode <= ERC_MODE_NORMAL;
    u_erc_host_model.send(1'b1, 5'h10);
    u_erc_host_model.send(1'b1, 5'h08);
    #1 chk({spi_fail_set, load_share_select}, 2'h0);
    chk(cfg_locked, ERC_CFG_INDEP);
    chk(aux_out_enable, 1'b0);
    u_erc_host_model.send(1'b1, 5'h14);
    #1 chk({aux_out_enable, aux_voltage_3v3}, 2'h3);
    @(posedge core_clk) shunt_at_threshold <= 1'b1;
    aux_out_low <= 1'b1;
    tick(1);
    chk({aux_overcurrent_flag, aux_undervoltage_flag}, 2'h3);
    u_erc_host_model.send(1'b0, 5'h00);
    #1 chk(aux_overcurrent_flag, 1'b1);
    @(posedge core_clk) shunt_at_threshold <= 1'b0;
    aux_out_low <= 1'b0;
    u_erc_host_model.send(1'b0, 5'h00);
    #1 chk({aux_overcurrent_flag, aux_current_limit}, 2'h0);
    chk(aux_undervoltage_flag, 1'b1);
    @(posedge core_clk) clr_undervoltage <= 1'b1;
    @(posedge core_clk) clr_undervoltage <= 1'b0;
    #1 chk(aux_undervoltage_flag, 1'b0);
    @(posedge core_clk) supply_low <= 1'b1;
    tick(2);
    chk(aux_regulator_on, 1'b0);
    u_erc_host_model.send(1'b1, 5'h15);
    tick(1);
    chk(aux_regulator_on, 1'b1);
    @(posedge core_clk) supply_low <= 1'b0;
    mode(ERC_MODE_FAILSAFE);
    chk(aux_regulator_on, 1'b0);
    @(posedge core_clk) soft_rst <= 1'b1;
    @(posedge core_clk) soft_rst <= 1'b0;
    #1 chk(cfg_locked, ERC_CFG_INDEP);
    chk(aux_out_enable, 1'b0);
  endtask
  task automatic t_share;
    @(posedge core_clk) nrst <= 1'b0;
    shunt_at_threshold <= 1'b1;
    aux_out_low <= 1'b1;
    sbc_mode <= ERC_MODE_NORMAL;
    @(posedge core_clk) nrst <= 1'b1;
    u_erc_host_model.send(1'b1, 5'h08);
    u_erc_host_model.send(1'b1, 5'h00);
    #1 chk({spi_fail_set, load_share_select}, 2'h3);
    chk(cfg_locked, ERC_CFG_SHARE);
    tick(1);
    chk({aux_overcurrent_flag, aux_undervoltage_flag}, 2'h0);
    chk(spi_fail_set, 1'b0);
    mode(ERC_MODE_STOP);
    chk({aux_regulator_on, load_share_select}, 2'h1);
    mode(ERC_MODE_NORMAL);
    chk(aux_regulator_on, 1'b1);
    u_erc_host_model.send(1'b1, 5'h0E);
    #1 chk({spi_fail_set, aux_voltage_3v3}, 2'h0);
    mode(ERC_MODE_STOP);
    chk(aux_regulator_on, 1'b1);
    mode(ERC_MODE_FAILSAFE);
    chk(aux_regulator_on, 1'b0);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    t_indep;
    t_share;
    complete_run;
  end
  initial begin
    repeat (400) @(posedge core_clk);
    err_total++;
    complete_run;
  end
endmodule
`default_nettype wire
